// File: inc/phy_cfg_pkg.sv
// Purpose: Shared constants and carriers for the port mode configuration block.
// Assumes: 100 MHz clock, eight ports, 16-bit management registers.
// Notes:   Register offsets are word indexes on the plain register port.
package phy_cfg_pkg;

    localparam int NUM_PORTS = 8;                          // Ports in the device.
    localparam int HALF_PORTS = 4;                         // Ports per section.

    // Register map of the plain register port (index, 16-bit data).
    localparam logic [7:0] REG_STATUS = 8'h00;             // Global strapped state, read only.
    localparam logic [7:0] REG_PORT_CTRL = 8'h10;          // Per-port control, 0x10 + port.
    localparam logic [7:0] REG_PORT_STAT = 8'h20;          // Per-port status, 0x20 + port.

    // Bit positions in the per-port control register.
    localparam int BIT_FIBER = 0;                          // Fiber select.
    localparam int BIT_XOVER_FORCE = 8;                    // Crossover force value.
    localparam int BIT_XOVER_EN = 9;                       // Auto crossover enable.
    localparam int BIT_AN_EN = 12;                         // Auto-negotiation enable.
    localparam int BIT_FORCE_100 = 13;                     // Forced speed 100.
    localparam int BIT_FORCE_FULL = 14;                    // Forced full duplex.

    // Reset values.
    localparam logic [15:0] PORT_CTRL_RST = 16'h1200;      // Negotiate, auto crossover.
    localparam int STRAP_WAIT = 4;                         // Cycles before straps are latched.

    // Normal link pulse period, 16 ms nominal.
    localparam int LINK_PULSE_PERIOD_US = 16000;
    localparam int CLK_MHZ = 100;
    localparam int LINK_PULSE_CYCLES = LINK_PULSE_PERIOD_US * CLK_MHZ;

    typedef enum logic [1:0] {
        IFACE_RMII,
        IFACE_SMII,
        IFACE_SS_SMII,
        IFACE_NONE
    } iface_t;

    typedef enum logic [1:0] {
        XO_STRAIGHT,
        XO_CROSSED,
        XO_AUTO
    } xover_t;

    typedef enum logic [1:0] {
        LINE_TX100,
        LINE_FX100,
        LINE_T10
    } line_t;

    // Line symbols sent by one port.
    typedef enum logic [1:0] {
        SYM_SILENT,
        SYM_IDLE,
        SYM_DATA,
        SYM_PULSE
    } sym_t;

    // Per-port effective configuration as seen by the data path.
    typedef struct packed {
        logic   fiber;
        logic   speed100;
        logic   full_duplex;
        logic   an_active;
        xover_t xover;
        line_t  line;
    } port_mode_t;

    // Per-port line inputs after synchronisation.
    typedef struct packed {
        logic pulse_seen;
        logic idle_seen;
        logic tx_data;
    } port_line_t;

endpackage : phy_cfg_pkg

// File: rtl/phy_port_mode_config.sv
// Purpose: Power-up strap sampling and per-port mode selection for an eight-port PHY.
// Assumes: Straps and line indications arrive asynchronously; registers are 16 bits.
// Notes:   Reads return data in the cycle after the read strobe.
// What this block does
// R1 - Sample straps at power-up; others negotiate
// R2 - Parallel detect: pulses mean 10, idles 100
// R3 - Half and full duplex at both speeds
// R4 - Section input splits into two four-port sections
// R5 - 100 copper sends idle symbols between frames
// R6 - 10 Mbps sends only link pulses when idle
// R7 - Crossover set by register field or pins
// R8 - Enable auto wins; else force picks straight/crossed
// R9 - Fiber bit one selects fiber mode
// R10 - Global fiber pin at reset sets all fiber
// R11 - Each port fiber bit written independently
// R12 - Fiber ports never negotiate
// R13 - MAC handles collisions for half-duplex fiber
// R14 - One MAC interface type for all ports
// R15 - Interface select sampled once at power-up
// R16 - Decode 00 RMII, 01 SMII, 10 SS-SMII
// R17 - Line decode follows fiber and speed
// R18 - Register bits numbered 0 to 15
// R19 - Reserved interface code leaves interface inactive
`timescale 1ns/100ps
module phy_port_mode_config
    import phy_cfg_pkg::*;
#(
    parameter int PULSE_CYC = LINK_PULSE_CYCLES            // Link pulse period in cycles.
) (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic [7:0]            reg_addr,
    input  wire logic [15:0]           reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic [15:0]                reg_rdata,
    input  wire logic                  global_fiber_select_pin,
    input  wire logic                  iface_select_high,
    input  wire logic                  iface_select_low,
    input  wire logic                  section_pin,
    input  wire logic                  auto_crossover_enable,
    input  wire logic                  crossover_force_value,
    input  wire logic                  force_pin,
    input  wire logic                  force_100_pin,
    input  wire logic                  force_full_pin,
    input  wire logic [NUM_PORTS-1:0]  normal_link_pulse,
    input  wire logic [NUM_PORTS-1:0]  idle_detect,
    input  wire logic [NUM_PORTS-1:0]  tx_frame,
    output port_mode_t [NUM_PORTS-1:0] port_mode,
    output sym_t [NUM_PORTS-1:0]       line_sym,
    output iface_t                     iface_mode,
    output logic                       split_sections,
    output logic                       straps_done
);

    // Overview of operation.
    // The block keeps one 16-bit control word per port and a few global
    // straps. The port_mode outputs are derived from those words and the
    // parallel detect results combinationally, so a write shows on port_mode one cycle later.
    //
    // Strap sampling.
    // After reset the strap pins pass a two-stage synchroniser. A short
    // settling count lets the second stage fill with stable values before
    // they are latched. The latch happens once per reset; later pin
    // changes are ignored until the next reset.
    // Limitation: a strap that moves in the settling window is caught at
    // whatever level it shows on the latching edge.
    //
    // Register port.
    // Index 0x00 returns the latched global state. Indexes 0x10 to 0x17
    // hold the per-port control words and 0x20 to 0x27 return the
    // effective per-port mode. Other indexes read as zero and drop writes.
    // Read data come from a flip-flop and stand for one cycle only, which
    // keeps the read path short at the cost of one cycle of latency.
    //
    // Write protection.
    // Writes before the straps are latched are dropped on purpose. The
    // latch overwrites every control word, so an early write would be
    // lost anyway, and dropping it makes the outcome timing independent.
    //
    // Parallel detection.
    // A negotiating copper port facing a partner without negotiation
    // takes its speed from the line: steady idle symbols mean 100 Mbps
    // and link pulses mean 10 Mbps. Idles win when both appear at once,
    // so the faster reading is kept. The last result is held while the
    // line is quiet.
    //
    // Fiber ports.
    // A port whose fiber bit is set never negotiates and always runs at
    // 100 Mbps. Duplex still follows the forced duplex bit. Collisions
    // in half duplex are left to the attached MAC.
    //
    // Crossover.
    // The enable bit selects automatic crossover and then the force bit
    // is a don't care; otherwise the force bit picks straight or crossed.
    //
    // MAC interface.
    // One interface type applies to all ports. The reserved strap code
    // leaves the interface inactive rather than guessing a type.
    //
    // Sections.
    // The section strap only reports the split to the surrounding logic.
    // Both halves share this register file, so software that runs two
    // management buses must keep to its own four ports.
    //
    // Link pulse timer.
    // Each port has a free-running timer that marks one pulse per period.
    // The period is a parameter so that a bench can shorten it. The
    // timers of all ports run in step, which is harmless because each
    // port drives its own line.
    //
    // Reset.
    // Reset is asynchronous and active high. It restores the default
    // control word on every port, clears the parallel detect results and
    // marks the interface inactive until the straps are latched again.

    // Width of the link pulse counter.
    localparam int NW = $clog2(PULSE_CYC + 1);

    // All state of the block.
    typedef struct packed {
        logic [2:0][7:0]                  sync1;     // First sync stage, read by sync2 only.
        logic [2:0][7:0]                  sync2;     // Second sync stage of line inputs.
        logic [7:0]                       psync1;    // First sync stage of strap pins.
        logic [7:0]                       psync2;    // Second sync stage of strap pins.
        logic [3:0]                       wait_cnt;  // Settling count before latching.
        logic                             done;      // Straps latched.
        iface_t                           iface;     // Latched interface mode.
        logic                             split;     // Latched section split.
        logic [NUM_PORTS-1:0][15:0]       ctrl;      // Per-port control registers.
        logic [NUM_PORTS-1:0]             pd_100;    // Parallel detect result per port.
        logic [NUM_PORTS-1:0][NW-1:0]     pulse_cnt; // Link pulse timers.
        logic [15:0]                      rdata;     // Read data register.
    } state_t;

    state_t s_q;
    state_t s_d;

    // Decodes the interface strap pair into a mode.
    function automatic iface_t decode_iface(input logic hi, input logic lo);
        case ({hi, lo})                                                   // R16
            2'b00:   decode_iface = IFACE_RMII;
            2'b01:   decode_iface = IFACE_SMII;
            2'b10:   decode_iface = IFACE_SS_SMII;
            default: decode_iface = IFACE_NONE;                           // R19
        endcase
    endfunction : decode_iface

    // Effective crossover mode from enable and force bits.
    function automatic xover_t decode_xover(input logic en, input logic frc);
        if (en) begin
            decode_xover = XO_AUTO;                                       // R8
        end else if (frc) begin
            decode_xover = XO_CROSSED;                                    // R8
        end else begin
            decode_xover = XO_STRAIGHT;                                   // R8
        end
    endfunction : decode_xover

    // Global fiber strap, synchronised apart from the other straps.
    // It stays out of the shared strap vector so that its two stages can
    // be followed on their own; only the second stage feeds the latch.
    logic fiber_strap_q;   // Synchronised fiber strap.
    logic fiber_s1_q;      // First sync stage of the fiber strap.

    // Next-state logic for the whole block.
    always_comb begin
        logic [3:0]  pidx;
        logic [15:0] strap_ctrl;
        s_d = s_q;
        pidx = reg_addr[3:0];
        strap_ctrl = PORT_CTRL_RST;
        // Synchronisers: pins are asynchronous to clk.
        s_d.sync1 = {tx_frame, idle_detect, normal_link_pulse};
        s_d.sync2 = s_q.sync1;
        s_d.psync1 = {crossover_force_value, auto_crossover_enable, force_full_pin,
                      force_100_pin, force_pin, section_pin, iface_select_high,
                      iface_select_low};
        s_d.psync2 = s_q.psync1;
        // Straps are latched once, after the synchronisers have settled.
        if (!s_q.done) begin
            if (s_q.wait_cnt == 4'(STRAP_WAIT)) begin
                s_d.done = 1'b1;                                          // R15
                s_d.iface = decode_iface(s_q.psync2[1], s_q.psync2[0]);   // R14
                s_d.split = s_q.psync2[2];                                // R4
                strap_ctrl[BIT_AN_EN] = ~s_q.psync2[3];                   // R1
                strap_ctrl[BIT_FORCE_100] = s_q.psync2[4];
                strap_ctrl[BIT_FORCE_FULL] = s_q.psync2[5];
                strap_ctrl[BIT_XOVER_EN] = s_q.psync2[6];                 // R7
                strap_ctrl[BIT_XOVER_FORCE] = s_q.psync2[7];              // R7
                strap_ctrl[BIT_FIBER] = fiber_strap_q;                    // R10
                for (int p = 0; p < NUM_PORTS; p++) begin
                    s_d.ctrl[p] = strap_ctrl;
                end
            end else begin
                s_d.wait_cnt = s_q.wait_cnt + 4'h1;
            end
        end
        // Register writes: one port at a time, other ports untouched.
        if (reg_wr && s_q.done && reg_addr[7:4] == REG_PORT_CTRL[7:4] && pidx < 4'(NUM_PORTS)) begin
            s_d.ctrl[pidx[2:0]] = reg_wdata;                              // R11 R18
        end
        // Register reads, answered in the following cycle.
        s_d.rdata = 16'h0000;
        if (reg_rd) begin
            if (reg_addr == REG_STATUS) begin
                s_d.rdata = {12'h000, s_q.done, s_q.split, s_q.iface};
            end else if (reg_addr[7:4] == REG_PORT_CTRL[7:4] && pidx < 4'(NUM_PORTS)) begin
                s_d.rdata = s_q.ctrl[pidx[2:0]];
            end else if (reg_addr[7:4] == REG_PORT_STAT[7:4] && pidx < 4'(NUM_PORTS)) begin
                s_d.rdata = {8'h00, port_mode[pidx[2:0]]};
            end
        end
        // Parallel detection and link pulse timers per port.
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (s_q.sync2[1][p]) begin
                s_d.pd_100[p] = 1'b1;                                     // R2
            end else if (s_q.sync2[0][p]) begin
                s_d.pd_100[p] = 1'b0;                                     // R2
            end
            if (s_q.pulse_cnt[p] == NW'(PULSE_CYC - 1)) begin
                s_d.pulse_cnt[p] = '0;
            end else begin
                s_d.pulse_cnt[p] = s_q.pulse_cnt[p] + NW'(1);
            end
        end
    end

    // Two-stage synchroniser for the fiber strap.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fiber_s1_q <= 1'b0;
            fiber_strap_q <= 1'b0;
        end else begin
            fiber_s1_q <= global_fiber_select_pin;
            fiber_strap_q <= fiber_s1_q;
        end
    end

    // State register.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
            for (int p = 0; p < NUM_PORTS; p++) begin
                s_q.ctrl[p] <= PORT_CTRL_RST;
            end
            s_q.iface <= IFACE_NONE;
        end else begin
            s_q <= s_d;
        end
    end

    // Per-port mode and line symbol outputs.
    generate
        for (genvar g = 0; g < NUM_PORTS; g++) begin : g_port
            logic fib;
            logic an;
            logic spd;
            assign fib = s_q.ctrl[g][BIT_FIBER];                          // R9
            assign an = s_q.ctrl[g][BIT_AN_EN] & ~fib;                    // R12
            // Negotiating copper ports use the parallel detect result.
            assign spd = fib | (an ? s_q.pd_100[g] : s_q.ctrl[g][BIT_FORCE_100]); // R2
            always_comb begin
                port_mode[g].fiber = fib;
                port_mode[g].speed100 = spd;
                port_mode[g].full_duplex = s_q.ctrl[g][BIT_FORCE_FULL];   // R3 R13
                port_mode[g].an_active = an;                              // R1
                port_mode[g].xover = decode_xover(s_q.ctrl[g][BIT_XOVER_EN],
                                                  s_q.ctrl[g][BIT_XOVER_FORCE]); // R8
                if (fib) begin
                    port_mode[g].line = LINE_FX100;                       // R17
                end else if (spd) begin
                    port_mode[g].line = LINE_TX100;                       // R17
                end else begin
                    port_mode[g].line = LINE_T10;                         // R17
                end
                if (s_q.sync2[2][g]) begin
                    line_sym[g] = SYM_DATA;
                end else if (spd) begin
                    line_sym[g] = SYM_IDLE;                               // R5
                end else if (s_q.pulse_cnt[g] == '0) begin
                    line_sym[g] = SYM_PULSE;                              // R6
                end else begin
                    line_sym[g] = SYM_SILENT;                             // R6
                end
            end
        end
    endgenerate

    assign reg_rdata = s_q.rdata;
    assign iface_mode = s_q.iface;                                        // R14
    assign split_sections = s_q.split;                                    // R4
    assign straps_done = s_q.done;

endmodule : phy_port_mode_config

// File: dv/phy_cfg_checker.sv
// Purpose: Concurrent checks on the port mode configuration block.
// Assumes: One clock domain; rst is asynchronous and active high.
// Notes:   Port 0 stands in for every port in the per-port checks except the fiber strap check, which covers all eight.
`timescale 1ns/100ps
module phy_cfg_checker
    import phy_cfg_pkg::*;
(
    input wire logic                       clk,
    input wire logic                       rst,
    input wire logic [7:0]                 reg_addr,
    input wire logic [15:0]                reg_wdata,
    input wire logic                       reg_wr,
    input wire logic                       reg_rd,
    input wire logic [15:0]                reg_rdata,
    input wire logic                       global_fiber_select_pin,
    input wire logic                       iface_select_high,
    input wire logic                       iface_select_low,
    input wire logic                       section_pin,
    input wire port_mode_t [NUM_PORTS-1:0] port_mode,
    input wire sym_t [NUM_PORTS-1:0]       line_sym,
    input wire iface_t                     iface_mode,
    input wire logic                       split_sections,
    input wire logic                       straps_done
);
    // One domain, so clock and reset are stated once.
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Writes only count once the straps are in, since the latch overwrites them.
    wire                 wr0 = reg_wr && reg_addr == REG_PORT_CTRL && straps_done;
    logic [NUM_PORTS-1:0] fib;                             // Fiber flags of all ports.
    // Gather the fiber flags so one check covers every port.
    always_comb begin
        for (int i = 0; i < NUM_PORTS; i++) fib[i] = port_mode[i].fiber;
    end
    a_strap_iface: assert property ($rose(straps_done) |=>
        iface_mode == iface_t'({iface_select_high, iface_select_low})) else $error("iface decode");
    a_strap_section: assert property ($rose(straps_done) |=> split_sections == section_pin)
        else $error("section strap");
    a_strap_fiber: assert property ($rose(straps_done) && global_fiber_select_pin |=> &fib)
        else $error("fiber strap");
    a_iface_hold: assert property (straps_done && $past(straps_done) |-> $stable(iface_mode))
        else $error("iface changed");
    a_xover_map: assert property (wr0 |=> port_mode[0].xover ==
        ($past(reg_wdata[BIT_XOVER_EN]) ? XO_AUTO :
         $past(reg_wdata[BIT_XOVER_FORCE]) ? XO_CROSSED : XO_STRAIGHT)) else $error("xover");
    a_fiber_own: assert property (wr0 |=> port_mode[0].fiber == $past(reg_wdata[BIT_FIBER])
        && $stable(port_mode[1].fiber)) else $error("fiber write");
    a_fiber_no_an: assert property (port_mode[0].fiber |->
        !port_mode[0].an_active && port_mode[0].line == LINE_FX100) else $error("fiber mode");
    a_tx_idle: assert property (port_mode[0].line == LINE_TX100 |-> line_sym[0] != SYM_SILENT)
        else $error("copper 100 silent");
    a_t10_quiet: assert property (port_mode[0].line == LINE_T10 |-> line_sym[0] != SYM_IDLE)
        else $error("10 Mbps idle symbol");
    a_read_gap: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data outside slot");
    a_stat_read: assert property (reg_rd && reg_addr == REG_PORT_STAT |=>
        reg_rdata[7:0] == $past(port_mode[0])) else $error("status read");
endmodule : phy_cfg_checker
bind phy_port_mode_config phy_cfg_checker i_phy_cfg_checker (.clk, .rst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .global_fiber_select_pin, .iface_select_high,
    .iface_select_low, .section_pin, .port_mode, .line_sym, .iface_mode, .split_sections,
    .straps_done);

// File: dv/link_partner_model.sv
// Purpose: Remote link partner without auto-negotiation, per port.
// Assumes: The period is the shortened link pulse period of the bench.
// Notes:   A partner that is absent shows neither idles nor pulses.
`timescale 1ns/100ps
module link_partner_model #(
    parameter int PERIOD = 16                              // Cycles between link pulses.
) (
    input  wire logic       clk,
    input  wire logic [7:0] present,                       // Partner attached.
    input  wire logic [7:0] fast,                          // Partner runs 100 Mbps.
    output logic [7:0]      pulse = 8'h00,                 // Link pulse seen.
    output logic [7:0]      idle = 8'h00                   // Idle symbols seen.
);
    int cnt = 0;                                           // Pulse period counter.
    // A fast partner idles steadily; a slow one only pulses, so detection is exercised.
    always @(posedge clk) begin
        cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
        idle <= present & fast;
        pulse <= (cnt == 0) ? (present & ~fast) : 8'h00;
    end
endmodule : link_partner_model

// File: dv/phy_port_mode_config_tb_top.sv
// Purpose: Self-checking bench for the port mode configuration block.
// Assumes: Reads answer one cycle after the strobe; straps settle before release.
// Notes:   Expected reads are queued by the driver and checked by a monitor.
`timescale 1ns/100ps
module phy_port_mode_config_tb_top;
    import phy_cfg_pkg::*;
    localparam int PER = 16;                               // Short pulse period.
    logic clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, rd_seen = 0;
    logic [7:0] reg_addr = 0, tx_frame = 0, present = 0, fast = 0;
    logic [15:0] reg_wdata = 0, reg_rdata;
    logic global_fiber_select_pin = 0, iface_select_high = 0, iface_select_low = 0;
    logic section_pin = 0, auto_crossover_enable = 1, crossover_force_value = 0;
    logic force_pin = 0, force_100_pin = 0, force_full_pin = 0, split_sections, straps_done;
    logic [7:0] normal_link_pulse, idle_detect;
    port_mode_t [NUM_PORTS-1:0] port_mode;
    sym_t [NUM_PORTS-1:0] line_sym;
    iface_t iface_mode;
    logic [31:0] exp_q[$];                                 // Mask high, value low.
    int bad_count = 0, total_checks = 0, cyc = 0;
    always #5 clk = ~clk;
    phy_port_mode_config #(.PULSE_CYC(PER)) i_phy_port_mode_config (.clk, .rst, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .global_fiber_select_pin, .iface_select_high,
        .iface_select_low, .section_pin, .auto_crossover_enable, .crossover_force_value,
        .force_pin, .force_100_pin, .force_full_pin, .normal_link_pulse, .idle_detect,
        .tx_frame, .port_mode, .line_sym, .iface_mode, .split_sections, .straps_done);
    link_partner_model #(.PERIOD(PER)) i_link_partner_model (.clk, .present, .fast,
        .pulse(normal_link_pulse), .idle(idle_detect));
    task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [15:0] m);
        @(posedge clk);
        {reg_rd, reg_wr, reg_addr} <= {2'b10, a};
        exp_q.push_back({m, e});
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        {reg_rd, reg_wr, reg_addr, reg_wdata} <= {2'b01, a, d};
    endtask : wr
    task automatic idle_bus(input int n);
        repeat (n) begin
            @(posedge clk);
            {reg_rd, reg_wr} <= 2'b00;
        end
    endtask : idle_bus
    task automatic cmp(input logic [15:0] got, input logic [31:0] ex);
        total_checks++;
        if ((got & ex[31:16]) !== (ex[15:0] & ex[31:16])) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, ex[15:0]);
        end
    endtask : cmp
    // Straps are set inside reset so they are stable from the release on.
    task automatic strap(input logic [1:0] c);
        rst <= 1'b1;
        {iface_select_high, iface_select_low} <= c;
        global_fiber_select_pin <= (c == 2'd1);
        force_pin <= (c == 2'd2);
        {section_pin, auto_crossover_enable, crossover_force_value} <= 3'($urandom);
        {force_100_pin, force_full_pin} <= 2'($urandom);
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 20 && straps_done !== 1'b1; i++) @(posedge clk);
    endtask : strap
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : conclude
    // Read data stand one cycle after the strobe; look mid-cycle, clear of the edge.
    always @(negedge clk) begin
        if (rd_seen) cmp(reg_rdata, exp_q.pop_front());
        rd_seen <= reg_rd;
    end
    // Random frames keep the symbol logic busy; a hang is cut short here.
    always @(posedge clk) begin
        tx_frame <= 8'($urandom);
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            conclude();
        end
    end
    initial begin
        void'($urandom(32'h34f5));
        for (int c = 0; c < 4; c++) begin
            idle_bus(2);
            strap(c[1:0]);
            rd(REG_STATUS, {12'h0, 1'b1, section_pin, c[1:0]}, 16'h000f);
            rd(REG_PORT_CTRL + 8'($urandom % 8),
               {3'b0, !force_pin, 11'h0, global_fiber_select_pin}, 16'h1001);
            rd(REG_PORT_STAT + 7, {8'h0, global_fiber_select_pin,
               global_fiber_select_pin || (force_pin && force_100_pin), force_full_pin,
               !force_pin && !global_fiber_select_pin,
               (auto_crossover_enable ? XO_AUTO :
                crossover_force_value ? XO_CROSSED : XO_STRAIGHT), 2'b0}, 16'h00fc);
            idle_bus(1);
            $display("test strap code %0d done", c);
        end
        for (int m = 0; m < 4; m++) begin
            wr(REG_PORT_CTRL, 16'h1000 | 16'(m << BIT_XOVER_FORCE));
            rd(REG_PORT_STAT, {12'h0, m[1] ? XO_AUTO : m[0] ? XO_CROSSED : XO_STRAIGHT, 2'b0},
               16'h000c);
        end
        wr(REG_PORT_CTRL + 2, 16'h1201);
        rd(REG_PORT_STAT + 2, {8'h0, 1'b1, 5'h0, LINE_FX100}, 16'h0093);
        rd(REG_PORT_STAT + 3, 16'h0000, 16'h0080);
        rd(8'h05, 16'h0000, 16'hffff);
        idle_bus(1);
        $display("test register control done");
        present <= 8'h10;
        fast <= 8'h10;
        idle_bus(4 * PER);
        rd(REG_PORT_STAT + 4, 16'h0040, 16'h0040);
        fast <= 8'h00;
        idle_bus(4 * PER);
        rd(REG_PORT_STAT + 4, 16'h0000, 16'h0040);
        idle_bus(3);
        $display("test parallel detect done");
        conclude();
    end
endmodule : phy_port_mode_config_tb_top
